// [design/partition_defines.svh]
// register offsets, field layout and constants of the partition registers
// Overview of operation
// - User RAM program base bits 31..16 read zero and ignore writes.
// - User RAM program base bits 15..10 are writable and set the user program start in data RAM.
// - User RAM program base bits 9..0 read zero, giving 1 KB steps.
// - Reset clears both user program base registers to zero.
// - The data RAM size register is a read-only 32-bit byte count.
// - The data RAM size reads 0x00008000 for 32 KB or 0x00010000 for 64 KB.
// - User flash program base bits 31..20 read zero and ignore writes.
// - User flash program base bits 19..11 are writable and set the user program start in flash.
// - User flash program base bits 10..0 read zero, giving 2 KB steps.
// - The flash size register is a read-only 32-bit byte count.
// - The flash size reads 0x00020000 for 128 KB or 0x00040000 for 256 KB.
// - A non-zero kernel RAM program base sets the kernel program start in data RAM.
`ifndef PARTITION_DEFINES_SVH
`define PARTITION_DEFINES_SVH

`define ADR_KERNEL_RAM_PROG  6'h00
`define ADR_USER_RAM_DATA    6'h04
`define ADR_USER_RAM_PROG    6'h08
`define ADR_DATA_RAM_SIZE    6'h0C
`define ADR_USER_FLASH_PROG  6'h10
`define ADR_FLASH_SIZE       6'h14
`define ADR_STATUS           6'h18

`define RAM_BASE_HI    15
`define RAM_BASE_LO    10
`define FLASH_BASE_HI  19
`define FLASH_BASE_LO  11

`define RAM_SIZE_32K     32'h0000_8000
`define RAM_SIZE_64K     32'h0001_0000
`define FLASH_SIZE_128K  32'h0002_0000
`define FLASH_SIZE_256K  32'h0004_0000
`define BASE_RESET       32'h0000_0000

`endif

// [design/partition_pkg.sv]
// types shared by the partition register block
package partition_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ACK
	} bus_state_type;

endpackage : partition_pkg

// [design/base_field_reg.sv]
// one coarse-granular base register: only bits hi..lo store
`timescale 1ns/1ps
`include "partition_defines.svh"
module base_field_reg
	import partition_pkg::*;
#(
	parameter int HI = 15,
	parameter int LO = 10
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] val_o
);

	typedef struct packed {
		logic [HI:LO] field;
	} state_type;

	state_type   s_q;
	state_type   s_d;
	logic [31:0] merged;

	always_comb begin
		merged = val_o;
		for (int b = 0; b < 4; b++) begin
			if (sel_i[b]) begin
				merged[b*8 +: 8] = dat_i[b*8 +: 8];
			end
		end
		s_d = s_q;
		if (wr_i) begin
			s_d.field = merged[HI:LO];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// bits outside hi..lo are constant zero, so writes never reach them
	always_comb begin
		val_o        = `BASE_RESET;
		val_o[HI:LO] = s_q.field;
	end

endmodule : base_field_reg

// [design/partition_regs.sv]
// partition configuration registers with a classic Wishbone slave
`timescale 1ns/1ps
`include "partition_defines.svh"
module partition_regs
	import partition_pkg::*;
#(
	parameter logic [31:0] RAM_SIZE   = `RAM_SIZE_64K,
	parameter logic [31:0] FLASH_SIZE = `FLASH_SIZE_256K
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [5:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	output logic [31:0]      kernel_ram_prog_base_o,
	output logic [31:0]      user_ram_data_base_o,
	output logic [31:0]      user_ram_prog_base_o,
	output logic [31:0]      user_flash_prog_base_o
);

	typedef struct packed {
		bus_state_type st;
		logic [31:0]   dat;
		logic          ack;
		logic          err;
		logic [31:0]   kpb;
		logic [31:0]   udb;
		logic [31:0]   upb;
		logic [31:0]   ufb;
	} state_type;

	state_type   s_q;
	state_type   s_d;
	wb_req_type  req;
	logic        take;
	logic        mapped;
	logic [31:0] rdata;
	logic [31:0] kpb_val;
	logic [31:0] udb_val;
	logic [31:0] upb_val;
	logic [31:0] ufb_val;
	logic [5:0]  status;

	assign req  = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
		sel: sel_i, dat: dat_i};
	assign take = req.cyc && req.stb && s_q.st == BUS_IDLE;

	base_field_reg #(.HI(`RAM_BASE_HI), .LO(`RAM_BASE_LO)) u_kpb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wr_i  (take && req.we && req.adr == `ADR_KERNEL_RAM_PROG),
		.sel_i (req.sel),
		.dat_i (req.dat),
		.val_o (kpb_val)
	);

	base_field_reg #(.HI(`RAM_BASE_HI), .LO(`RAM_BASE_LO)) u_udb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wr_i  (take && req.we && req.adr == `ADR_USER_RAM_DATA),
		.sel_i (req.sel),
		.dat_i (req.dat),
		.val_o (udb_val)
	);

	base_field_reg #(.HI(`RAM_BASE_HI), .LO(`RAM_BASE_LO)) u_upb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wr_i  (take && req.we && req.adr == `ADR_USER_RAM_PROG),
		.sel_i (req.sel),
		.dat_i (req.dat),
		.val_o (upb_val)
	);

	base_field_reg #(.HI(`FLASH_BASE_HI), .LO(`FLASH_BASE_LO)) u_ufb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wr_i  (take && req.we && req.adr == `ADR_USER_FLASH_PROG),
		.sel_i (req.sel),
		.dat_i (req.dat),
		.val_o (ufb_val)
	);

	// software ordering is not enforced; status shows each check live
	always_comb begin
		status    = '0;
		status[0] = udb_val > kpb_val;
		status[1] = upb_val > udb_val;
		status[2] = upb_val <= RAM_SIZE;
		status[3] = ufb_val <= FLASH_SIZE;
		status[4] = kpb_val <= RAM_SIZE;
		status[5] = udb_val <= RAM_SIZE;
	end

	always_comb begin
		mapped = 1'b1;
		rdata  = '0;
		case (req.adr)
			`ADR_KERNEL_RAM_PROG: rdata = kpb_val;
			`ADR_USER_RAM_DATA:   rdata = udb_val;
			`ADR_USER_RAM_PROG:   rdata = upb_val;
			`ADR_DATA_RAM_SIZE:   rdata = RAM_SIZE;
			`ADR_USER_FLASH_PROG: rdata = ufb_val;
			`ADR_FLASH_SIZE:      rdata = FLASH_SIZE;
			`ADR_STATUS:          rdata = {26'h0, status};
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// one wait state: answer in the cycle after the request is taken
	always_comb begin
		s_d     = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		case (s_q.st)
			BUS_IDLE: begin
				if (take) begin
					s_d.st  = BUS_ACK;
					s_d.ack = mapped;
					s_d.err = !mapped;
					s_d.dat = (mapped && !req.we) ? rdata : '0;
				end
			end
			BUS_ACK: begin
				s_d.st = BUS_IDLE;
			end
			default: begin
				s_d.st = BUS_IDLE;
			end
		endcase
		s_d.kpb = kpb_val;
		s_d.udb = udb_val;
		s_d.upb = upb_val;
		s_d.ufb = ufb_val;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '{st: BUS_IDLE, dat: '0, ack: 1'b0, err: 1'b0,
				kpb: '0, udb: '0, upb: '0, ufb: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign dat_o                  = s_q.dat;
	assign ack_o                  = s_q.ack;
	assign err_o                  = s_q.err;
	assign kernel_ram_prog_base_o = s_q.kpb;
	assign user_ram_data_base_o   = s_q.udb;
	assign user_ram_prog_base_o   = s_q.upb;
	assign user_flash_prog_base_o = s_q.ufb;

endmodule : partition_regs

// [verif/partition_regs_chk.sv]
// assertions on the partition register block ports
`timescale 1ns/1ps
module partition_regs_chk
	import partition_pkg::*;
#(
	parameter logic [31:0] RAM_SIZE   = 32'h0001_0000,
	parameter logic [31:0] FLASH_SIZE = 32'h0004_0000
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [5:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic [31:0] user_ram_prog_base_o,
	input wire logic [31:0] user_flash_prog_base_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ram_high_zero: assert property (user_ram_prog_base_o[31:16] == 16'h0)
		else $error("ram base high bits set");
	chk_ram_low_zero: assert property (user_ram_prog_base_o[9:0] == 10'h0)
		else $error("ram base low bits set");
	chk_flash_high_zero: assert property (user_flash_prog_base_o[31:20] == 12'h0)
		else $error("flash base high bits set");
	chk_flash_low_zero: assert property (user_flash_prog_base_o[10:0] == 11'h0)
		else $error("flash base low bits set");
	chk_reset_clears: assert property ($fell(rst_i) |->
		user_ram_prog_base_o == 32'h0 && user_flash_prog_base_o == 32'h0)
		else $error("base not cleared by reset");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_req_answer: assert property ($rose(stb_i) && cyc_i |=> ack_o || err_o)
		else $error("request not answered");
	chk_ram_size: assert property ($rose(stb_i) && cyc_i && !we_i &&
		adr_i == 6'h0C |=> dat_o == RAM_SIZE)
		else $error("ram size read wrong");
	chk_flash_size: assert property ($rose(stb_i) && cyc_i && !we_i &&
		adr_i == 6'h14 |=> dat_o == FLASH_SIZE)
		else $error("flash size read wrong");
endmodule : partition_regs_chk

bind partition_regs partition_regs_chk #(.RAM_SIZE(RAM_SIZE),
	.FLASH_SIZE(FLASH_SIZE)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_o, .ack_o, .err_o, .user_ram_prog_base_o,
	.user_flash_prog_base_o);

// [verif/partition_regs_bench.sv]
// random and corner tests of the partition registers
`timescale 1ns/1ps
`include "partition_defines.svh"
module partition_regs_bench;
	import partition_pkg::*;
	logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
	logic        we_i = 1'h0, ack_o, err_o, e;
	logic [5:0]  adr_i = 6'h0;
	logic [3:0]  sel_i = 4'h0, s;
	logic [31:0] dat_i = 32'h0, dat_o, kb, ud, up, uf, q, v, eu, ef;
	int          err_total = 0, n_tests = 0;
	partition_regs #(.RAM_SIZE(`RAM_SIZE_32K), .FLASH_SIZE(`FLASH_SIZE_128K))
	u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .err_o, .kernel_ram_prog_base_o(kb),
		.user_ram_data_base_o(ud), .user_ram_prog_base_o(up),
		.user_flash_prog_base_o(uf));
	initial forever #20 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [31:0] x, g);
		n_tests++;
		if (x !== g) begin
			$display("BAD %s exp %h got %h", n, x, g);
			err_total++;
		end
	endtask : chk
	// entered just after a rising edge; dat_o/err_o taken at the ack edge
	task automatic wb(input logic w, input logic [5:0] a,
		input logic [3:0] sl, input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		sel_i <= sl;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
		if (n >= 20) begin
			err_total++;
			complete_run;
		end
		q = dat_o;
		e = err_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : wb
	function automatic logic [31:0] mrg(logic [31:0] o, d, logic [3:0] sl,
		logic [31:0] m);
		for (int b = 0; b < 4; b++) if (sl[b]) o[8*b+:8] = d[8*b+:8];
		return o & m;
	endfunction : mrg
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial begin
		v = $urandom(68176);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, 6'h08, 4'hF, 32'h0); chk("ram base", 32'h0, q);
		wb(1'h0, 6'h10, 4'hF, 32'h0); chk("flash base", 32'h0, q);
		wb(1'h0, 6'h0C, 4'hF, 32'h0); chk("ram size", 32'h8000, q);
		wb(1'h0, 6'h14, 4'hF, 32'h0); chk("flash size", 32'h20000, q);
		$display("reset test done");
		eu = 32'h0;
		ef = 32'h0;
		for (int i = 0; i < 24; i++) begin
			// first pass all lanes, all ones under the mask: sets every writable bit but ram base bit 15 and flash base bits 19..17 and 15
			s = (i == 0) ? 4'hF : 4'($urandom);
			// software side: bases stay within 32 KB ram and 128 KB flash
			v = ((i == 0) ? 32'hFFFF_FFFF : $urandom) & 32'hFFF1_7FFF;
			wb(1'h1, 6'h08, s, v);
			eu = mrg(eu, v, s, 32'h0000_FC00);
			wb(1'h0, 6'h08, 4'hF, 32'h0); chk("ram base", eu, q);
			chk("ram base port", eu, up);
			wb(1'h1, 6'h10, s, v);
			ef = mrg(ef, v, s, 32'h000F_F800);
			wb(1'h0, 6'h10, 4'hF, 32'h0); chk("flash base", ef, q);
			chk("flash base port", ef, uf);
			wb(1'h1, 6'h0C, s, v);
			wb(1'h1, 6'h14, s, v);
			wb(1'h0, 6'h0C, 4'hF, 32'h0); chk("ram size", 32'h8000, q);
			wb(1'h0, 6'h14, 4'hF, 32'h0); chk("flash size", 32'h20000, q);
		end
		$display("write test done");
		wb(1'h1, 6'h00, 4'hF, 32'h0000_0400);
		wb(1'h1, 6'h04, 4'hF, 32'h0000_0800);
		wb(1'h1, 6'h08, 4'hF, 32'h0000_1000);
		eu = 32'h0000_1000;
		wb(1'h0, 6'h00, 4'hF, 32'h0); chk("kernel base", 32'h400, q);
		chk("kernel base port", 32'h400, kb);
		wb(1'h0, 6'h04, 4'hF, 32'h0); chk("user data", 32'h800, q);
		chk("user data port", 32'h800, ud);
		wb(1'h0, 6'h18, 4'hF, 32'h0); chk("status", 32'h3F, q);
		$display("ordering test done");
		wb(1'h1, 6'h1C, 4'hF, v);
		chk("unmapped err", 32'h1, {31'h0, e});
		wb(1'h0, 6'h08, 4'hF, 32'h0); chk("ram base kept", eu, q);
		rst_i <= 1'h1;
		@(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, 6'h08, 4'hF, 32'h0); chk("ram base", 32'h0, q);
		wb(1'h0, 6'h10, 4'hF, 32'h0); chk("flash base", 32'h0, q);
		$display("second reset test done");
		complete_run;
	end
	// about 625 cycles expected; wide margin for slow answers
	initial begin
		#400000;
		err_total++;
		complete_run;
	end
endmodule : partition_regs_bench
